// [common/bmt_regs.vh]
// register offsets, field layout, reset values and timing for the measurement tracker
`ifndef BMT_REGS_VH
`define BMT_REGS_VH
`define BMT_ADDR_THERMAL_READING 8'h08
`define BMT_ADDR_CELL_VOLTAGE 8'h09
`define BMT_ADDR_CURRENT_READING 8'h0A
`define BMT_ADDR_MEAN_CURRENT 8'h0B
`define BMT_ADDR_MEAN_THERMAL 8'h16
`define BMT_ADDR_MEAN_VOLTAGE 8'h19
`define BMT_ADDR_THERMAL_EXTREMES 8'h1A
`define BMT_ADDR_VOLTAGE_EXTREMES 8'h1B
`define BMT_ADDR_CURRENT_EXTREMES 8'h1C
`define BMT_ADDR_THERM_CONFIG 8'h1D
`define BMT_ADDR_THERM_GAIN 8'h2C
`define BMT_ADDR_THERM_OFFSET 8'h2D
`define BMT_ADDR_THERM_CURVE 8'h2E
`define BMT_VOLT_EXT_INIT 16'h00FF
`define BMT_SIGNED_EXT_INIT 16'h807F
`define BMT_CFG_THERMAL_SOURCE_SELECT_BIT 0
`define BMT_CFG_RESET 16'h0000
`define BMT_GAIN_RESET 16'h0100
`define BMT_OFFSET_RESET 16'h0000
`define BMT_CURVE_RESET 16'h0000
`define BMT_VOLT_EXT_SHIFT 8
`define BMT_CURR_EXT_SHIFT 8
`define BMT_TEMP_EXT_SHIFT 8
`define BMT_AVG_SHIFT 3
`define BMT_CURR_POS_SAT 16'h7FFF
`define BMT_CURR_NEG_SAT 16'h8000
`define BMT_SETTLE_TIME_NS 10000
`define BMT_CLK_PERIOD_NS 25
`define BMT_SETTLE_CYCLES ((`BMT_SETTLE_TIME_NS + `BMT_CLK_PERIOD_NS - 1) / `BMT_CLK_PERIOD_NS)
`define BMT_THERM_PERIOD_CYCLES 400000
`define BMT_BIAS_LIMIT_CYCLES 16'h0400
`define BMT_PEAK_MSB 15
`define BMT_PEAK_LSB 8
`define BMT_FLOOR_MSB 7
`define BMT_FLOOR_LSB 0
`endif

// [src/bmt_extreme_track.v]
// one peak and floor byte pair with host restart
`timescale 1ns/1ps
module bmt_extreme_track #(
  parameter SIGNED_FIELDS = 1,
  parameter [15:0] INIT_VALUE = 16'h807F,
  parameter SHIFT = 8
) (
  input wire clk_in,
  input wire nrst_in,
  input wire sample_in,
  input wire [15:0] sample_data_in,
  input wire write_in,
  input wire [15:0] write_data_in,
  output wire [15:0] extremes_out
);
  reg [7:0] peak_reg;
  reg [7:0] floor_reg;
  wire [15:0] shifted = sample_data_in >> SHIFT;
  wire [7:0] coarse = shifted[7:0];
  wire peak_lt;
  wire floor_gt;
  // signed fields compare with their sign bits flipped
  wire [7:0] flip = SIGNED_FIELDS ? 8'h80 : 8'h00;
  assign peak_lt = (peak_reg ^ flip) < (coarse ^ flip);
  assign floor_gt = (floor_reg ^ flip) > (coarse ^ flip);
  assign extremes_out = {peak_reg, floor_reg};
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      peak_reg <= INIT_VALUE[15:8];
      floor_reg <= INIT_VALUE[7:0];
    end else if (write_in) begin
      // a host write loads the field pair; the restart value reopens tracking
      peak_reg <= write_data_in[15:8];
      floor_reg <= write_data_in[7:0];
    end else if (sample_in) begin
      if (peak_lt) begin
        peak_reg <= coarse;
      end
      if (floor_gt) begin
        floor_reg <= coarse;
      end
    end
  end
endmodule

// [src/bmt_tracker.v]
// measurement result, average and extremes registers with thermistor sequencing
`timescale 1ns/1ps
`include "bmt_regs.vh"
module bmt_tracker #(
  parameter THERM_PERIOD = `BMT_THERM_PERIOD_CYCLES,
  parameter SENSE_WIDTH = 18
) (
  input wire clk_in,
  input wire nrst_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  output reg [15:0] reg_rdata_out,
  output reg reg_ack_out,
  input wire volt_valid_in,
  input wire [15:0] volt_data_in,
  input wire curr_valid_in,
  input wire signed [SENSE_WIDTH-1:0] curr_sense_in,
  input wire die_valid_in,
  input wire [15:0] die_temp_in,
  output reg therm_convert_out,
  input wire therm_valid_in,
  input wire [15:0] therm_ratio_in,
  output reg thermistor_bias_pin_out,
  output reg [15:0] gauge_temp_out
);
  localparam ST_IDLE = 2'b00;
  localparam ST_SETTLE = 2'b01;
  localparam ST_SAMPLE = 2'b10;
  localparam [15:0] SETTLE_CYCLES = `BMT_SETTLE_CYCLES;
  localparam [15:0] BIAS_LIMIT = `BMT_BIAS_LIMIT_CYCLES;
  reg [15:0] thermal_reading_reg;
  reg [15:0] cell_voltage_reading_reg;
  reg [15:0] current_reading_reg;
  reg [15:0] mean_current_reading_reg;
  reg [15:0] mean_thermal_reading_reg;
  reg [15:0] mean_cell_voltage_reg;
  reg [15:0] config_reg;
  reg [15:0] gain_coeff_reg;
  reg [15:0] offset_coeff_reg;
  reg [15:0] curve_coeff_reg;
  reg [1:0] state_reg;
  reg [31:0] period_cnt_reg;
  reg [15:0] settle_cnt_reg;
  reg temp_update_reg;
  reg volt_update_reg;
  reg curr_update_reg;
  reg [15:0] bias_cnt_reg;
  wire bias_limit = bias_cnt_reg >= BIAS_LIMIT - 16'h0001;
  wire thermal_source_select = config_reg[`BMT_CFG_THERMAL_SOURCE_SELECT_BIT];
  wire [15:0] voltage_extremes;
  wire [15:0] current_extremes;
  wire [15:0] thermal_extremes;
  // peak and floor bytes of each extremes word
  wire [7:0] voltage_peak_field = voltage_extremes[`BMT_PEAK_MSB:`BMT_PEAK_LSB];
  wire [7:0] voltage_floor_field = voltage_extremes[`BMT_FLOOR_MSB:`BMT_FLOOR_LSB];
  wire [7:0] current_peak_field = current_extremes[`BMT_PEAK_MSB:`BMT_PEAK_LSB];
  wire [7:0] current_floor_field = current_extremes[`BMT_FLOOR_MSB:`BMT_FLOOR_LSB];
  wire [7:0] thermal_peak_field = thermal_extremes[`BMT_PEAK_MSB:`BMT_PEAK_LSB];
  wire [7:0] thermal_floor_field = thermal_extremes[`BMT_FLOOR_MSB:`BMT_FLOOR_LSB];
  wire wr_volt_ext = reg_wr_in && (reg_addr_in == `BMT_ADDR_VOLTAGE_EXTREMES);
  wire wr_curr_ext = reg_wr_in && (reg_addr_in == `BMT_ADDR_CURRENT_EXTREMES);
  wire wr_temp_ext = reg_wr_in && (reg_addr_in == `BMT_ADDR_THERMAL_EXTREMES);
  // current saturation: clamp the wide sense code to the 16-bit span
  wire signed [SENSE_WIDTH-1:0] pos_lim = {{(SENSE_WIDTH-16){1'b0}}, `BMT_CURR_POS_SAT};
  wire signed [SENSE_WIDTH-1:0] neg_lim = {{(SENSE_WIDTH-16){1'b1}}, `BMT_CURR_NEG_SAT};
  reg [15:0] curr_clamped;
  always @* begin
    if (curr_sense_in > pos_lim) begin
      curr_clamped = `BMT_CURR_POS_SAT;
    end else if (curr_sense_in < neg_lim) begin
      curr_clamped = `BMT_CURR_NEG_SAT;
    end else begin
      curr_clamped = curr_sense_in[15:0];
    end
  end
  // thermistor ratio to temperature: gain in 1/256 steps, offset, quadratic curve term
  wire signed [16:0] ratio_s = {1'b0, therm_ratio_in};
  wire signed [33:0] gain_prod = ratio_s * $signed({1'b0, gain_coeff_reg});
  wire signed [15:0] ratio_hi = $signed({8'h00, therm_ratio_in[15:8]});
  wire signed [31:0] curve_prod = ratio_hi * ratio_hi * $signed(curve_coeff_reg);
  wire [15:0] therm_temp = gain_prod[23:8] + offset_coeff_reg + curve_prod[23:8];
  wire [15:0] selected_temp = thermal_source_select ? therm_temp : die_temp_in;
  wire take_temp = thermal_source_select ? (state_reg == ST_SAMPLE && therm_valid_in)
                                          : die_valid_in;
  // running average: exponential, weight one eighth; cheap and keeps no history
  function [15:0] avg_step;
    input [15:0] mean;
    input [15:0] sample;
    input is_signed;
    reg [16:0] diff;
    reg [16:0] step;
    begin
      diff = {is_signed & sample[15], sample} - {is_signed & mean[15], mean};
      if (is_signed | diff[16]) begin
        step = {{`BMT_AVG_SHIFT{diff[16]}}, diff[16:`BMT_AVG_SHIFT]};
      end else begin
        step = diff >> `BMT_AVG_SHIFT;
      end
      avg_step = mean + step[15:0];
    end
  endfunction
  // voltage channel
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      cell_voltage_reading_reg <= 16'h0000;
      mean_cell_voltage_reg <= 16'h0000;
      volt_update_reg <= 1'b0;
    end else begin
      volt_update_reg <= volt_valid_in;
      if (volt_valid_in) begin
        cell_voltage_reading_reg <= volt_data_in;
        mean_cell_voltage_reg <= avg_step(mean_cell_voltage_reg, volt_data_in, 1'b0);
      end
    end
  end
  // current channel
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      current_reading_reg <= 16'h0000;
      mean_current_reading_reg <= 16'h0000;
      curr_update_reg <= 1'b0;
    end else begin
      curr_update_reg <= curr_valid_in;
      if (curr_valid_in) begin
        current_reading_reg <= curr_clamped;
        mean_current_reading_reg <= avg_step(mean_current_reading_reg, curr_clamped, 1'b1);
      end
    end
  end
  // temperature channel; gauging sees the same value as the thermal reading
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      thermal_reading_reg <= 16'h0000;
      mean_thermal_reading_reg <= 16'h0000;
      gauge_temp_out <= 16'h0000;
      temp_update_reg <= 1'b0;
    end else begin
      temp_update_reg <= take_temp;
      if (take_temp) begin
        thermal_reading_reg <= selected_temp;
        gauge_temp_out <= selected_temp;
        mean_thermal_reading_reg <= avg_step(mean_thermal_reading_reg, selected_temp, 1'b1);
      end
    end
  end
  // bias-on time; a converter that never answers must not hold the divider biased
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      bias_cnt_reg <= 16'h0000;
    end else if (!thermistor_bias_pin_out) begin
      bias_cnt_reg <= 16'h0000;
    end else if (!bias_limit) begin
      bias_cnt_reg <= bias_cnt_reg + 16'h0001;
    end
  end
  // thermistor sequencer; settling is short against the period so bias duty stays tiny
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      state_reg <= ST_IDLE;
      period_cnt_reg <= 32'h00000000;
      settle_cnt_reg <= 16'h0000;
      thermistor_bias_pin_out <= 1'b0;
      therm_convert_out <= 1'b0;
    end else begin
      therm_convert_out <= 1'b0;
      if (period_cnt_reg >= THERM_PERIOD - 1) begin
        period_cnt_reg <= 32'h00000000;
      end else begin
        period_cnt_reg <= period_cnt_reg + 32'h00000001;
      end
      case (state_reg)
        ST_IDLE: begin
          if (thermal_source_select && period_cnt_reg == 32'h00000000) begin
            thermistor_bias_pin_out <= 1'b1;
            settle_cnt_reg <= 16'h0000;
            state_reg <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (settle_cnt_reg >= SETTLE_CYCLES - 16'h0001) begin
            therm_convert_out <= 1'b1;
            state_reg <= ST_SAMPLE;
          end else begin
            settle_cnt_reg <= settle_cnt_reg + 16'h0001;
          end
        end
        ST_SAMPLE: begin
          if (therm_valid_in || !thermal_source_select) begin
            thermistor_bias_pin_out <= 1'b0;
            state_reg <= ST_IDLE;
          end else if (bias_limit) begin
            thermistor_bias_pin_out <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          thermistor_bias_pin_out <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
  // coefficient and configuration registers
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      config_reg <= `BMT_CFG_RESET;
      gain_coeff_reg <= `BMT_GAIN_RESET;
      offset_coeff_reg <= `BMT_OFFSET_RESET;
      curve_coeff_reg <= `BMT_CURVE_RESET;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `BMT_ADDR_THERM_CONFIG: begin
          config_reg <= reg_wdata_in;
        end
        `BMT_ADDR_THERM_GAIN: begin
          gain_coeff_reg <= reg_wdata_in;
        end
        `BMT_ADDR_THERM_OFFSET: begin
          offset_coeff_reg <= reg_wdata_in;
        end
        `BMT_ADDR_THERM_CURVE: begin
          curve_coeff_reg <= reg_wdata_in;
        end
        default: begin
          config_reg <= config_reg;
        end
      endcase
    end
  end
  bmt_extreme_track #(
    .SIGNED_FIELDS(0),
    .INIT_VALUE(`BMT_VOLT_EXT_INIT),
    .SHIFT(`BMT_VOLT_EXT_SHIFT)
  ) u_volt_ext (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .sample_in(volt_update_reg),
    .sample_data_in(cell_voltage_reading_reg),
    .write_in(wr_volt_ext),
    .write_data_in(reg_wdata_in),
    .extremes_out(voltage_extremes)
  );
  bmt_extreme_track #(
    .SIGNED_FIELDS(1),
    .INIT_VALUE(`BMT_SIGNED_EXT_INIT),
    .SHIFT(`BMT_CURR_EXT_SHIFT)
  ) u_curr_ext (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .sample_in(curr_update_reg),
    .sample_data_in(current_reading_reg),
    .write_in(wr_curr_ext),
    .write_data_in(reg_wdata_in),
    .extremes_out(current_extremes)
  );
  bmt_extreme_track #(
    .SIGNED_FIELDS(1),
    .INIT_VALUE(`BMT_SIGNED_EXT_INIT),
    .SHIFT(`BMT_TEMP_EXT_SHIFT)
  ) u_temp_ext (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .sample_in(temp_update_reg),
    .sample_data_in(thermal_reading_reg),
    .write_in(wr_temp_ext),
    .write_data_in(reg_wdata_in),
    .extremes_out(thermal_extremes)
  );
  // read port: registered data, one cycle after the strobe; unmapped reads zero
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 16'h0000;
      reg_ack_out <= 1'b0;
    end else begin
      reg_ack_out <= reg_rd_in | reg_wr_in;
      if (reg_rd_in) begin
        case (reg_addr_in)
          `BMT_ADDR_THERMAL_READING: begin
            reg_rdata_out <= thermal_reading_reg;
          end
          `BMT_ADDR_CELL_VOLTAGE: begin
            reg_rdata_out <= cell_voltage_reading_reg;
          end
          `BMT_ADDR_CURRENT_READING: begin
            reg_rdata_out <= current_reading_reg;
          end
          `BMT_ADDR_MEAN_CURRENT: begin
            reg_rdata_out <= mean_current_reading_reg;
          end
          `BMT_ADDR_MEAN_THERMAL: begin
            reg_rdata_out <= mean_thermal_reading_reg;
          end
          `BMT_ADDR_MEAN_VOLTAGE: begin
            reg_rdata_out <= mean_cell_voltage_reg;
          end
          `BMT_ADDR_THERMAL_EXTREMES: begin
            reg_rdata_out <= {thermal_peak_field, thermal_floor_field};
          end
          `BMT_ADDR_VOLTAGE_EXTREMES: begin
            reg_rdata_out <= {voltage_peak_field, voltage_floor_field};
          end
          `BMT_ADDR_CURRENT_EXTREMES: begin
            reg_rdata_out <= {current_peak_field, current_floor_field};
          end
          `BMT_ADDR_THERM_CONFIG: begin
            reg_rdata_out <= config_reg;
          end
          `BMT_ADDR_THERM_GAIN: begin
            reg_rdata_out <= gain_coeff_reg;
          end
          `BMT_ADDR_THERM_OFFSET: begin
            reg_rdata_out <= offset_coeff_reg;
          end
          `BMT_ADDR_THERM_CURVE: begin
            reg_rdata_out <= curve_coeff_reg;
          end
          default: begin
            reg_rdata_out <= 16'h0000;
          end
        endcase
      end
    end
  end
endmodule

// [verif/bmt_tracker_chk.sv]
// assertion checker for the measurement tracker ports
`timescale 1ns/1ps
module bmt_tracker_chk #(
  parameter THERM_PERIOD = 400000,
  parameter SENSE_WIDTH = 18
) (
  input wire clk_in,
  input wire nrst_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [7:0] reg_addr_in,
  input wire [15:0] reg_wdata_in,
  input wire [15:0] reg_rdata_out,
  input wire reg_ack_out,
  input wire volt_valid_in,
  input wire [15:0] volt_data_in,
  input wire curr_valid_in,
  input wire signed [SENSE_WIDTH-1:0] curr_sense_in,
  input wire die_valid_in,
  input wire [15:0] die_temp_in,
  input wire therm_convert_out,
  input wire therm_valid_in,
  input wire [15:0] therm_ratio_in,
  input wire thermistor_bias_pin_out,
  input wire [15:0] gauge_temp_out
);
  reg [12:0] run_reg;
  reg armed_reg;
  reg seen_reg;
  wire ext_addr = reg_addr_in == 8'h1A || reg_addr_in == 8'h1B || reg_addr_in == 8'h1C;
  wire any_valid = volt_valid_in | curr_valid_in | die_valid_in | therm_valid_in;
  function [15:0] sat(input signed [SENSE_WIDTH-1:0] v);
    begin
      if (v > 32767) sat = 16'h7FFF;
      else if (v < -32768) sat = 16'h8000;
      else sat = v[15:0];
    end
  endfunction
  // run length saturates so a stuck bias cannot wrap back under the bound
  always @(posedge clk_in) begin
    if (!nrst_in) begin
      run_reg <= 13'h0000;
      armed_reg <= 1'b0;
      seen_reg <= 1'b0;
    end else begin
      run_reg <= !thermistor_bias_pin_out ? 13'h0000 : run_reg + (run_reg != 13'h1FFF);
      armed_reg <= therm_convert_out | (armed_reg & !therm_valid_in);
      seen_reg <= seen_reg | volt_valid_in | curr_valid_in | die_valid_in | therm_valid_in
        | reg_wr_in;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  a_ack_after_strobe: assert property ((reg_rd_in || reg_wr_in) |=> reg_ack_out)
    else $error("no acknowledge after strobe");
  a_ack_has_cause: assert property (reg_ack_out |-> $past(reg_rd_in || reg_wr_in))
    else $error("acknowledge without strobe");
  a_volt_reading: assert property (
    volt_valid_in ##1 !volt_valid_in ##1 (reg_rd_in && reg_addr_in == 8'h09)
    |=> reg_rdata_out == $past(volt_data_in, 3)) else $error("cell voltage reading wrong");
  a_curr_saturate: assert property (
    curr_valid_in ##1 !curr_valid_in ##1 (reg_rd_in && reg_addr_in == 8'h0A)
    |=> reg_rdata_out == sat($past(curr_sense_in, 3))) else $error("current reading wrong");
  a_ext_init_value: assert property (
    reg_rd_in && ext_addr && !seen_reg
    |=> reg_rdata_out == ($past(reg_addr_in) == 8'h1B ? 16'h00FF : 16'h807F))
    else $error("extremes not at initial value");
  a_ext_host_load: assert property (
    (reg_wr_in && ext_addr && !any_valid) ##2
    (reg_rd_in && reg_addr_in == $past(reg_addr_in, 2))
    |=> reg_rdata_out == $past(reg_wdata_in, 3)) else $error("extremes write not taken");
  a_settle_wait: assert property (
    $rose(therm_convert_out) |-> thermistor_bias_pin_out && run_reg >= 13'h018F)
    else $error("conversion before settling");
  a_convert_pulse: assert property (therm_convert_out |=> !therm_convert_out)
    else $error("convert longer than one cycle");
  a_bias_release: assert property (therm_valid_in && armed_reg |=> !thermistor_bias_pin_out)
    else $error("bias left on after sample");
  // bound is one percent of the default conversion period
  a_bias_duty: assert property (run_reg < 13'h0FA0)
    else $error("bias on too long");
  a_gauge_match: assert property (
    reg_rd_in && reg_addr_in == 8'h08 |=> reg_rdata_out == $past(gauge_temp_out))
    else $error("gauging temperature differs from reading");
endmodule
bind bmt_tracker bmt_tracker_chk #(.THERM_PERIOD(THERM_PERIOD), .SENSE_WIDTH(SENSE_WIDTH))
  i_bmt_tracker_chk (.clk_in(clk_in), .nrst_in(nrst_in), .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out), .volt_valid_in(volt_valid_in),
  .volt_data_in(volt_data_in), .curr_valid_in(curr_valid_in), .curr_sense_in(curr_sense_in),
  .die_valid_in(die_valid_in), .die_temp_in(die_temp_in), .therm_convert_out(therm_convert_out),
  .therm_valid_in(therm_valid_in), .therm_ratio_in(therm_ratio_in),
  .thermistor_bias_pin_out(thermistor_bias_pin_out), .gauge_temp_out(gauge_temp_out));

// [verif/bmt_host_model.sv]
// host register access model driving the decoded word strobes
`timescale 1ns/1ps
module bmt_host_model (
  input wire clk_in,
  input wire [15:0] reg_rdata_in,
  input wire reg_ack_in,
  output reg reg_wr_out = 1'b0,
  output reg reg_rd_out = 1'b0,
  output reg [7:0] reg_addr_out = 8'hFF,
  output reg [15:0] reg_wdata_out = 16'h0000
);
  integer i;
  task xfer(input wr, input [7:0] addr, input [15:0] wdata, output [15:0] rdata, output ok);
    begin
      @(posedge clk_in);
      #1;
      reg_wr_out = wr;
      reg_rd_out = !wr;
      reg_addr_out = addr;
      reg_wdata_out = wdata;
      @(posedge clk_in);
      #1;
      reg_wr_out = 1'b0;
      reg_rd_out = 1'b0;
      // address and data are not held past the strobe, so do not leave them looking valid
      reg_addr_out = ~addr;
      reg_wdata_out = ~wdata;
      for (i = 0; i < 4 && reg_ack_in !== 1'b1; i = i + 1) @(posedge clk_in) #1;
      ok = reg_ack_in === 1'b1;
      rdata = reg_rdata_in;
    end
  endtask
endmodule

// [verif/bmt_tracker_bench.sv]
// self-checking bench for the measurement tracker
`timescale 1ns/1ps
module bmt_tracker_bench;
  reg clk_in = 1'b0;
  reg nrst_in = 1'b0;
  reg volt_valid_in = 1'b0, curr_valid_in = 1'b0, die_valid_in = 1'b0, therm_valid_in = 1'b0;
  reg [15:0] volt_data_in = 16'h0000, die_temp_in = 16'h0000, therm_ratio_in = 16'h0000;
  reg signed [17:0] curr_sense_in = 18'h00000;
  wire reg_wr_in, reg_rd_in, reg_ack_out, therm_convert_out, thermistor_bias_pin_out;
  wire [7:0] reg_addr_in;
  wire [15:0] reg_wdata_in, reg_rdata_out, gauge_temp_out;
  reg [15:0] d, lf = 16'h0026, e, ratio_q;
  reg ok;
  reg signed [7:0] p, f;
  integer n, miscompares = 0, n_checks = 0;
  bmt_tracker #(.THERM_PERIOD(1000)) i_bmt_tracker (.clk_in(clk_in), .nrst_in(nrst_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
    .volt_valid_in(volt_valid_in), .volt_data_in(volt_data_in), .curr_valid_in(curr_valid_in),
    .curr_sense_in(curr_sense_in), .die_valid_in(die_valid_in), .die_temp_in(die_temp_in),
    .therm_convert_out(therm_convert_out), .therm_valid_in(therm_valid_in),
    .therm_ratio_in(therm_ratio_in), .thermistor_bias_pin_out(thermistor_bias_pin_out),
    .gauge_temp_out(gauge_temp_out));
  bmt_host_model i_bmt_host_model (.clk_in(clk_in), .reg_rdata_in(reg_rdata_out),
    .reg_ack_in(reg_ack_out), .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
    .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in));
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [15:0] sat(input signed [17:0] v);
    sat = v > 32767 ? 16'h7FFF : (v < -32768 ? 16'h8000 : v[15:0]);
  endfunction
  // thermistor result for gain x2, offset 10h, curve 100h
  function [15:0] tconv(input [15:0] r);
    tconv = {r[14:0], 1'b0} + 16'h0010 + r[15:8] * r[15:8];
  endfunction
  task test_done;
    begin
      if (miscompares == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task acc(input wr, input [7:0] a, input [15:0] v);
    begin
      i_bmt_host_model.xfer(wr, a, v, d, ok);
      chk({15'h0000, ok}, 16'h0001);
      if (ok !== 1'b1) test_done;
    end
  endtask
  task rdc(input [7:0] a, input [15:0] exp);
    begin
      acc(1'b0, a, 16'h0000);
      chk(d, exp);
    end
  endtask
  task smp(input [1:0] k, input [17:0] v);
    begin
      @(posedge clk_in);
      #1;
      {volt_data_in, die_temp_in, curr_sense_in} = {v[15:0], v[15:0], v};
      {volt_valid_in, curr_valid_in, die_valid_in} = {k == 2'h0, k == 2'h1, k == 2'h2};
      @(posedge clk_in);
      #1;
      {volt_valid_in, curr_valid_in, die_valid_in} = 3'h0;
      {volt_data_in, die_temp_in, curr_sense_in} = ~{volt_data_in, die_temp_in, curr_sense_in};
    end
  endtask
  task waitb(input lvl);
    begin
      for (n = 0; n < 1500 && thermistor_bias_pin_out !== lvl; n = n + 1) @(posedge clk_in) #1;
      chk({15'h0000, thermistor_bias_pin_out}, {15'h0000, lvl});
      if (n >= 1500) test_done;
    end
  endtask
  // thermistor converter answers a few cycles after each start pulse
  initial begin
    forever begin
      @(posedge clk_in);
      #1;
      if (therm_convert_out === 1'b1) begin
        repeat (3) @(posedge clk_in);
        #1;
        {therm_valid_in, therm_ratio_in} = {1'b1, ratio_q};
        @(posedge clk_in);
        #1;
        {therm_valid_in, therm_ratio_in} = {1'b0, ~ratio_q};
      end
    end
  end
  initial forever #12.5 clk_in = ~clk_in;
  initial begin
    repeat (3) @(posedge clk_in);
    #1;
    nrst_in = 1'b1;
    rdc(8'h1A, 16'h807F);
    rdc(8'h1B, 16'h00FF);
    rdc(8'h1C, 16'h807F);
    rdc(8'h00, 16'h0000);
    {p, f} = 16'h00FF;
    for (n = 0; n < 12; n = n + 1) begin
      lf = lfsr(lf);
      smp(2'h0, {2'h0, lf});
      rdc(8'h09, lf);
      if (n == 0) rdc(8'h19, lf >> 3);
      p = lf[15:8] > $unsigned(p) ? lf[15:8] : p;
      f = lf[15:8] < $unsigned(f) ? lf[15:8] : f;
      rdc(8'h1B, {p, f});
    end
    acc(1'b1, 8'h1B, 16'h00FF);
    smp(2'h0, 18'h05A00);
    rdc(8'h1B, 16'h5A5A);
    {p, f} = 16'h807F;
    for (n = 0; n < 8; n = n + 1) begin
      lf = lfsr(lf);
      e = sat(n == 0 ? 18'h1FFFF : n == 1 ? 18'h20000 : n == 2 ? 18'h08000 :
        n == 3 ? 18'h37FFF : {{2{lf[15]}}, lf});
      smp(2'h1, n == 0 ? 18'h1FFFF : n == 1 ? 18'h20000 : n == 2 ? 18'h08000 :
        n == 3 ? 18'h37FFF : {{2{lf[15]}}, lf});
      rdc(8'h0A, e);
      if (n == 0) rdc(8'h0B, 16'h0FFF);
      p = $signed(e[15:8]) > p ? e[15:8] : p;
      f = $signed(e[15:8]) < f ? e[15:8] : f;
      rdc(8'h1C, {p, f});
    end
    acc(1'b1, 8'h1C, 16'h807F);
    rdc(8'h1C, 16'h807F);
    acc(1'b1, 8'h2D, 16'h0010);
    acc(1'b1, 8'h2C, 16'h0200);
    acc(1'b1, 8'h2E, 16'h0100);
    {p, f} = 16'h807F;
    for (n = 0; n < 6; n = n + 1) begin
      lf = n == 0 ? 16'h1900 : lfsr(lf);
      smp(2'h2, {2'h0, lf});
      rdc(8'h08, lf);
      chk(gauge_temp_out, lf);
      if (n == 0) rdc(8'h16, 16'h0320);
      p = $signed(lf[15:8]) > p ? lf[15:8] : p;
      f = $signed(lf[15:8]) < f ? lf[15:8] : f;
      rdc(8'h1A, {p, f});
    end
    acc(1'b1, 8'h1D, 16'h0001);
    acc(1'b1, 8'h1A, 16'h807F);
    for (e = 0; e < 2; e = e + 1) begin
      ratio_q = e == 0 ? 16'h1234 : 16'h07F0;
      waitb(1'b1);
      waitb(1'b0);
      rdc(8'h08, tconv(ratio_q));
    end
    rdc(8'h1A, 16'h2510);
    test_done;
  end
endmodule
